// File: iats_abort_status.sv
// Transmit abort cause register, flush count and AXI4-Lite slave
// Functional notes
// - Read-only 32-bit register naming abort causes
// - Clear-register reads wipe all; bit 9 comes back if still due
// - Bit 9 clear with cause present: one-cycle drop
// - Bits 31:23 count flushed transmit commands
// - Disabling controller zeroes the flush count
// - Bit 16: master saw software abort
// - Bit 15: read command written during slave-read
// - Bit 14 slave lost bus, bit 12 too
// - Slave loss: sampled data differs at rise
// - Read request with queued data: flush, bit 13
// - Bit 12 set when master loses arbitration
// - Bit 9: start byte without restart
// - Abort flag empties the transmit queue level
//
// Design decision made here: register access over AXI4-Lite.
`include "iats_params.svh"
module iats_abort_status #(
   parameter int ADDR_W = `IATS_ADDR_W,   // Register address width
   parameter int LVL_W  = `IATS_LEVEL_W   // Transmit queue level width
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              clkEn,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // Controller core status
   input  wire logic              masterMode,
   input  wire logic              masterAbortDet,
   input  wire logic              masterArbLost,
   input  wire logic              slaveReadServing,
   input  wire logic              slaveReadReq,
   input  wire logic              slaveTxActive,
   input  wire logic              sdaDrive,
   input  wire logic              txPop,
   // Bus pins, asynchronous
   input  wire logic              sclPin,
   input  wire logic              sdaPin,
   // Controls to the core
   output logic                   i2cEnable,
   output logic                   userAbortReq,
   output logic                   restartEn,
   output logic                   txAbortFlag,
   output logic                   txFlush,
   output logic [LVL_W-1:0]       txLevel
);
   localparam int FW = `IATS_FLUSH_W;     // Flush count width

   // Write channel holding state
   logic [ADDR_W-1:0] awAddr;            // Captured write address
   logic              awHeld;            // Write address taken
   logic [31:0]       wData;             // Captured write data
   logic [3:0]        wStrb;             // Captured byte enables
   logic              wHeld;             // Write data taken
   // Software registers
   logic [31:0]       controlReg;        // Restart enable lives here
   logic [31:0]       targetReg;         // Cmd_sel_a and start-byte selects
   logic [1:0]        enableReg;         // Enable and abort request
   // Cause state
   logic              causeUser;         // Software abort seen
   logic              causeMisuse;       // Read command in slave read
   logic              causeSlvArb;       // Slave lost the bus
   logic              causeStale;        // Stale data flushed
   logic              causeArb;          // Arbitration lost
   logic [FW-1:0]     flushCount;        // Commands discarded
   iats_pkg::iats_sbyte_e sbyteState;    // Start-byte cause phase
   // Pin synchronisers and filtered levels
   logic [2:0]        sclSync;           // Clock pin chain
   logic [2:0]        sdaSync;           // Data pin chain
   logic              sclLevel;          // Agreed clock level
   logic              sdaLevel;          // Agreed data level
   // Combinational decode
   logic              doWrite;           // Both write halves present
   logic              readHs;            // Read address accepted
   logic              clrEv;             // Clear-register read
   logic              dataCmdWr;         // Data command write
   logic [31:0]       wordNew;           // Strobe-merged write word
   logic              sclAgree;          // Clock stages agree
   logic              sdaAgree;          // Data stages agree
   logic              sclRise;           // Qualified clock rising edge
   logic              sdaNow;            // Data level at this cycle
   logic              sbyteCond;         // Start-byte cause persists
   logic              evUser;            // Software abort event
   logic              evMisuse;          // Slave read misuse event
   logic              evSlvArb;          // Slave bus loss event
   logic              evStale;           // Stale flush event
   logic              evArb;             // Arbitration loss event
   logic              evSbyte;           // Start-byte attempt event
   logic              abortEv;           // Any abort this cycle
   logic              pushOk;            // Command enters the queue
   logic              lvlClr;            // Empty the queue level
   logic [31:0]       causeWord;         // Assembled cause register
   logic [31:0]       rdNext;            // Read data for araddr
   logic              rdMapped;          // Read address decodes

   // Merge byte lanes of a write into an old value
   function automatic logic [31:0] mergeWord(input logic [31:0] oldW,
                                              input logic [31:0] newW,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = oldW;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = newW[i*8 +: 8];
         end
      end
      return res;
   endfunction : mergeWord

   // Handshake readies; low while frozen
   assign awready = clkEn & ~awHeld;
   assign wready  = clkEn & ~wHeld;
   assign arready = clkEn & ~rvalid;

   // Channel events
   assign doWrite   = clkEn & awHeld & wHeld & ~bvalid;
   assign readHs    = arvalid & arready;
   assign clrEv     = readHs & (araddr == `IATS_OFS_ABRT_CLR ||
                                araddr == `IATS_OFS_ALL_CLR);
   assign dataCmdWr = doWrite & (awAddr == `IATS_OFS_DATA_CMD);
   assign wordNew   = mergeWord(32'h0000_0000, wData, wStrb);

   // Write address capture
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         awHeld <= 1'b0;
         awAddr <= '0;
      end else if (clkEn) begin
         if (awvalid && awready) begin
            awHeld <= 1'b1;
            awAddr <= awaddr;
         end else if (doWrite) begin
            awHeld <= 1'b0;
         end
      end
   end

   // Write data capture
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wHeld <= 1'b0;
         wData <= '0;
         wStrb <= '0;
      end else if (clkEn) begin
         if (wvalid && wready) begin
            wHeld <= 1'b1;
            wData <= wvalid ? wdata : wData;
            wStrb <= wstrb;
         end else if (doWrite) begin
            wHeld <= 1'b0;
         end
      end
   end

   // Write response; unmapped addresses answer SLVERR
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bvalid <= 1'b0;
         bresp  <= `IATS_RESP_OKAY;
      end else if (clkEn) begin
         if (doWrite) begin
            bvalid <= 1'b1;
            case (awAddr)
               `IATS_OFS_CONTROL, `IATS_OFS_TARGET, `IATS_OFS_DATA_CMD,
               `IATS_OFS_RAW_IRQ, `IATS_OFS_ALL_CLR, `IATS_OFS_ABRT_CLR,
               `IATS_OFS_ENABLE, `IATS_OFS_TX_LEVEL,
               `IATS_OFS_CAUSE: bresp <= `IATS_RESP_OKAY;
               default:         bresp <= `IATS_RESP_SLVERR;
            endcase
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Control and target registers; cause offset is not writable
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         controlReg <= `IATS_RESET_WORD;
         targetReg  <= `IATS_RESET_WORD;
      end else if (doWrite) begin
         if (awAddr == `IATS_OFS_CONTROL) begin
            controlReg <= mergeWord(controlReg, wData, wStrb);
         end
         if (awAddr == `IATS_OFS_TARGET) begin
            targetReg <= mergeWord(targetReg, wData, wStrb);
         end
      end
   end

   // Enable register; abort request drops once the master acts on it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         enableReg <= 2'h0;
      end else if (clkEn) begin
         if (doWrite && awAddr == `IATS_OFS_ENABLE && wStrb[0]) begin
            enableReg <= wData[1:0];
         end else if (evUser) begin
            enableReg[`IATS_BIT_ABORT] <= 1'b0;
         end
      end
   end

   assign i2cEnable    = enableReg[`IATS_BIT_EN];
   assign userAbortReq = enableReg[`IATS_BIT_ABORT];
   assign restartEn    = controlReg[`IATS_BIT_RESTART];

   // Pin synchronisers, three stages each
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sclSync <= 3'h7;
         sdaSync <= 3'h7;
      end else if (clkEn) begin
         sclSync <= {sclSync[1:0], sclPin};
         sdaSync <= {sdaSync[1:0], sdaPin};
      end
   end

   // Second and third stage agreement decides a change
   assign sclAgree = (sclSync[1] == sclSync[2]);
   assign sdaAgree = (sdaSync[1] == sdaSync[2]);
   assign sclRise  = sclAgree & sclSync[1] & ~sclLevel;
   assign sdaNow   = sdaAgree ? sdaSync[1] : sdaLevel;

   // Filtered pin levels
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sclLevel <= 1'b1;
         sdaLevel <= 1'b1;
      end else if (clkEn) begin
         if (sclAgree) begin
            sclLevel <= sclSync[1];
         end
         if (sdaAgree) begin
            sdaLevel <= sdaSync[1];
         end
      end
   end

   // Abort cause events
   assign evUser   = masterMode & userAbortReq & masterAbortDet;
   assign evMisuse = dataCmdWr & slaveReadServing &
                     wordNew[`IATS_BIT_READ_CMD];
   assign evSlvArb = slaveTxActive & sclRise & (sdaNow != sdaDrive);
   assign evStale  = clkEn & slaveReadReq & (txLevel != '0);
   assign evArb    = (clkEn & masterArbLost) | evSlvArb;
   assign sbyteCond = ~restartEn & targetReg[`IATS_BIT_CMD_SEL_A] &
                      targetReg[`IATS_BIT_GC_START];
   assign evSbyte  = dataCmdWr & masterMode & sbyteCond;
   assign abortEv  = evUser | evMisuse | evSlvArb | evStale | evArb | evSbyte;

   // Queue level: aborted commands never enter; abort or disable empties it
   assign pushOk = dataCmdWr & ~evMisuse & ~evSbyte;
   assign lvlClr = abortEv | txAbortFlag | ~i2cEnable;

   iats_level_cnt #(
      .W       (LVL_W)
   ) u_level (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clkEn   (clkEn),
      .inc     (pushOk),
      .dec     (txPop),
      .clr     (lvlClr),
      .level   (txLevel)
   );

   // Sticky cause bits; a new event beats a clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         causeUser   <= 1'b0;
         causeMisuse <= 1'b0;
         causeSlvArb <= 1'b0;
         causeStale  <= 1'b0;
         causeArb    <= 1'b0;
      end else if (clkEn) begin
         causeUser   <= evUser   | (causeUser   & ~clrEv);
         causeMisuse <= evMisuse | (causeMisuse & ~clrEv);
         causeSlvArb <= evSlvArb | (causeSlvArb & ~clrEv);
         causeStale  <= evStale  | (causeStale  & ~clrEv);
         causeArb    <= evArb    | (causeArb    & ~clrEv);
      end
   end

   // Start-byte cause: a clear drops it one cycle, then it returns if still due
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sbyteState <= iats_pkg::SB_CLEAR;
      end else if (clkEn) begin
         case (sbyteState)
            iats_pkg::SB_CLEAR: begin
               if (evSbyte) begin
                  sbyteState <= iats_pkg::SB_SET;
               end
            end
            iats_pkg::SB_SET: begin
               if (clrEv && !evSbyte) begin
                  sbyteState <= iats_pkg::SB_DROPPED;
               end
            end
            iats_pkg::SB_DROPPED: begin
               if (sbyteCond || evSbyte) begin
                  sbyteState <= iats_pkg::SB_SET;
               end else begin
                  sbyteState <= iats_pkg::SB_CLEAR;
               end
            end
            default: begin
               sbyteState <= iats_pkg::SB_CLEAR;
            end
         endcase
      end
   end

   // Flushed command count; disable zeroes it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flushCount <= '0;
      end else if (clkEn) begin
         if (!i2cEnable) begin
            flushCount <= '0;
         end else if (abortEv && !txAbortFlag) begin
            flushCount <= FW'(txLevel);
         end else if (clrEv) begin
            flushCount <= '0;
         end
      end
   end

   // Raw abort flag and one-cycle flush strobe to the queue
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         txAbortFlag <= 1'b0;
         txFlush     <= 1'b0;
      end else if (clkEn) begin
         txAbortFlag <= abortEv | (txAbortFlag & ~clrEv);
         txFlush     <= abortEv;
      end
   end

   // Assembled cause register
   always_comb begin
      causeWord = `IATS_RESET_WORD;
      causeWord[`IATS_FLUSH_LSB +: FW] = flushCount;
      causeWord[`IATS_BIT_USER]    = causeUser;
      causeWord[`IATS_BIT_MISUSE]  = causeMisuse;
      causeWord[`IATS_BIT_SLV_ARB] = causeSlvArb;
      causeWord[`IATS_BIT_STALE]   = causeStale;
      causeWord[`IATS_BIT_ARB]     = causeArb;
      causeWord[`IATS_BIT_SBYTE]   = (sbyteState == iats_pkg::SB_SET);
   end

   // Read decode
   always_comb begin
      rdNext   = 32'h0000_0000;
      rdMapped = 1'b1;
      case (araddr)
         `IATS_OFS_CONTROL:  rdNext = controlReg;
         `IATS_OFS_TARGET:   rdNext = targetReg;
         `IATS_OFS_ENABLE:   rdNext = {30'h0000_0000, enableReg};
         `IATS_OFS_TX_LEVEL: rdNext = 32'(txLevel);
         `IATS_OFS_CAUSE:    rdNext = causeWord;
         `IATS_OFS_RAW_IRQ:  rdNext[`IATS_BIT_RAW_ABRT] = txAbortFlag;
         `IATS_OFS_DATA_CMD, `IATS_OFS_ALL_CLR,
         `IATS_OFS_ABRT_CLR: rdNext = 32'h0000_0000;
         default:            rdMapped = 1'b0;
      endcase
   end

   // Read response, registered
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rvalid <= 1'b0;
         rdata  <= `IATS_RESET_WORD;
         rresp  <= `IATS_RESP_OKAY;
      end else if (clkEn) begin
         if (readHs) begin
            rvalid <= 1'b1;
            rdata  <= rdNext;
            rresp  <= rdMapped ? `IATS_RESP_OKAY : `IATS_RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end
endmodule : iats_abort_status

// File: iats_params.svh
// Offsets, field positions, reset values and widths of the abort status block
`ifndef IATS_PARAMS_SVH
`define IATS_PARAMS_SVH
`define IATS_ADDR_W        8
`define IATS_OFS_CONTROL   8'h00
`define IATS_OFS_TARGET    8'h04
`define IATS_OFS_DATA_CMD  8'h10
`define IATS_OFS_RAW_IRQ   8'h34
`define IATS_OFS_ALL_CLR   8'h40
`define IATS_OFS_ABRT_CLR  8'h54
`define IATS_OFS_ENABLE    8'h6C
`define IATS_OFS_TX_LEVEL  8'h74
`define IATS_OFS_CAUSE     8'h80
`define IATS_BIT_RESTART   5
`define IATS_BIT_GC_START  10
`define IATS_BIT_CMD_SEL_A   11
`define IATS_BIT_EN        0
`define IATS_BIT_ABORT     1
`define IATS_BIT_READ_CMD  8
`define IATS_BIT_RAW_ABRT  6
`define IATS_BIT_SBYTE     9
`define IATS_BIT_ARB       12
`define IATS_BIT_STALE     13
`define IATS_BIT_SLV_ARB   14
`define IATS_BIT_MISUSE    15
`define IATS_BIT_USER      16
`define IATS_FLUSH_LSB     23
`define IATS_FLUSH_W       9
`define IATS_LEVEL_W       5
`define IATS_RESET_WORD    32'h0000_0000
`define IATS_RESP_OKAY     2'h0
`define IATS_RESP_SLVERR   2'h2
`endif

// File: iats_pkg.sv
// Types shared by the abort status block
package iats_pkg;
   // Phase of the start-byte-without-restart cause bit
   typedef enum logic [1:0] {
      SB_CLEAR,
      SB_SET,
      SB_DROPPED
   } iats_sbyte_e;
   typedef logic [31:0] iats_word_t;
endpackage : iats_pkg

// File: iats_level_cnt.sv
// Transmit queue level counter with priority clear
module iats_level_cnt #(
   parameter int W = 5
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         clkEn,
   input  wire logic         inc,
   input  wire logic         dec,
   input  wire logic         clr,
   output logic [W-1:0]      level
);
   localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
   localparam logic [W-1:0] MAX = {W{1'b1}};

   // Clear beats counting; saturates at both ends
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         level <= '0;
      end else if (clkEn) begin
         if (clr) begin
            level <= '0;
         end else if (inc && !dec && level != MAX) begin
            level <= level + ONE;
         end else if (dec && !inc && level != '0) begin
            level <= level - ONE;
         end
      end
   end
endmodule : iats_level_cnt

// File: iats_abort_status_asserts.sv
// Port-level concurrent checks for the abort status block
module iats_abort_status_asserts #(
   parameter int LVL_W = 5
) (
   input wire logic             clk,
   input wire logic             sys_rst,
   input wire logic             clkEn,
   input wire logic             arvalid,
   input wire logic             arready,
   input wire logic             rvalid,
   input wire logic             masterMode,
   input wire logic             masterAbortDet,
   input wire logic             masterArbLost,
   input wire logic             slaveReadReq,
   input wire logic             i2cEnable,
   input wire logic             userAbortReq,
   input wire logic             txAbortFlag,
   input wire logic             txFlush,
   input wire logic [LVL_W-1:0] txLevel
);
   // One clock domain, reset disables all checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_USER_ABORT: assert property (clkEn && masterMode && userAbortReq
      && masterAbortDet |=> txAbortFlag && txFlush && !userAbortReq)
      else $error("user abort not recorded");
   AST_ARBITRATION_LOST: assert property (clkEn && masterArbLost |=> txAbortFlag && txFlush)
      else $error("arbitration loss not recorded");
   AST_STALE_FLUSH: assert property (clkEn && slaveReadReq && txLevel != '0
      |=> txAbortFlag && txFlush && txLevel == '0) else $error("stale data not flushed");
   AST_LEVEL_ZERO: assert property (txAbortFlag |-> txLevel == '0)
      else $error("queue level nonzero while abort flag high");
   AST_DISABLED: assert property (clkEn && !i2cEnable ##1 clkEn |-> txLevel == '0)
      else $error("queue level kept while disabled");
   AST_FLAG_HOLD: assert property (clkEn && txAbortFlag && i2cEnable && !arvalid
      |=> txAbortFlag) else $error("abort flag dropped without a clear read");
   AST_RESET_ZERO: assert property ($fell(sys_rst)
      |-> !txAbortFlag && !txFlush && txLevel == '0 && !i2cEnable) else $error("reset state wrong");
   AST_AR_ANSWER: assert property (arvalid && arready |=> rvalid)
      else $error("read not answered in one cycle");
   AST_READY_LOW: assert property (rvalid |-> !arready)
      else $error("read address accepted while answer pending");
endmodule : iats_abort_status_asserts

bind iats_abort_status iats_abort_status_asserts #(.LVL_W(LVL_W)) u_asserts (
   .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .arvalid(arvalid), .arready(arready),
   .rvalid(rvalid), .masterMode(masterMode), .masterAbortDet(masterAbortDet),
   .masterArbLost(masterArbLost), .slaveReadReq(slaveReadReq), .i2cEnable(i2cEnable),
   .userAbortReq(userAbortReq), .txAbortFlag(txAbortFlag), .txFlush(txFlush),
   .txLevel(txLevel)
);

// File: iats_bus_partner.sv
// Remote bus party: one data bit slot on the pulled-up clock and data lines
module iats_bus_partner (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic launch,
   input  wire logic bitLvl,
   output logic      sclPin,
   output logic      sdaPin
);
   logic [4:0] phase;  // Slot position, zero means lines released
   // Walk the slot once per launch
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase <= 5'h00;
      end else if (launch || phase != 5'h00) begin
         phase <= (phase == 5'h12) ? 5'h00 : phase + 5'h01;
      end
   end
   // Low, high, low clock; data released before clock returns high
   assign sclPin = (phase == 5'h00) || (phase >= 5'h07 && phase < 5'h0D);
   assign sdaPin = (phase == 5'h00 || phase >= 5'h10) ? 1'b1 : bitLvl;
endmodule : iats_bus_partner

// File: iats_abort_status_tb.sv
// Self-checking bench for the abort status block
`include "iats_params.svh"
module iats_abort_status_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {int kind; int pushes; logic [31:0] cause;} iats_row_s;
   logic clk = 0, sys_rst = 1, clkEn = 1, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, masterMode = 0, masterAbortDet = 0, masterArbLost = 0;
   logic slaveReadServing = 0, slaveReadReq = 0, slaveTxActive = 0, sdaDrive = 0;
   logic txPop = 0, launch = 0, bitLvl = 1, sclPin, sdaPin;
   logic awready, wready, bvalid, arready, rvalid, i2cEnable, userAbortReq, restartEn;
   logic txAbortFlag, txFlush;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0]  wstrb = 4'hF;
   logic [1:0]  bresp, rresp, rs;
   logic [4:0]  txLevel;
   int          bad_count = 0, check_count = 0, cycles = 0;
   // Cause kinds: 0 user abort, 1 master arb, 2 slave loss, 3 stale, 4 misuse, 5 no loss
   iats_row_s rows [6] = '{
      '{0, 3, 32'h0181_0000},
      '{1, 31, 32'h0F80_1000},
      '{2, 2, 32'h0100_5000},
      '{3, 1, 32'h0080_2000},
      '{4, 5, 32'h0280_8000},
      '{5, 2, 32'h0000_0000}};
   iats_abort_status dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .masterMode(masterMode), .masterAbortDet(masterAbortDet),
      .masterArbLost(masterArbLost), .slaveReadServing(slaveReadServing),
      .slaveReadReq(slaveReadReq), .slaveTxActive(slaveTxActive), .sdaDrive(sdaDrive),
      .txPop(txPop), .sclPin(sclPin), .sdaPin(sdaPin), .i2cEnable(i2cEnable),
      .userAbortReq(userAbortReq), .restartEn(restartEn), .txAbortFlag(txAbortFlag),
      .txFlush(txFlush), .txLevel(txLevel));
   iats_bus_partner remote (.clk(clk), .sys_rst(sys_rst), .launch(launch), .bitLvl(bitLvl),
      .sclPin(sclPin), .sdaPin(sdaPin));
   // Free-running clock and hang guard
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         complete_run();
      end
   end
   // Compare one word and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Write cycle: address and data together, each released when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic pa, pw, pb, ta, tw, tk;
      pa = 1;
      pw = 1;
      pb = 1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (pb) begin
         @(negedge clk);
         ta = pa && awready;
         tw = pw && wready;
         tk = bvalid;
         r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tk) bready <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
         pb = !tk;
      end
      @(posedge clk);
   endtask : axi_wr
   // Read cycle, answer compared against expected data and response
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic pa, pb, ta, tk;
      logic [31:0] d;
      logic [1:0] r;
      pa = 1;
      pb = 1;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (pb) begin
         @(negedge clk);
         ta = pa && arready;
         tk = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (tk) rready <= 1'b0;
         pa = pa && !ta;
         pb = !tk;
      end
      @(posedge clk);
      chk(d, exp);
      chk({30'h0, r}, {30'h0, er});
   endtask : rd_chk
   // Drive the stimulus of the given kind; kind 5 raises no abort cause
   task automatic fire(input int k);
      masterMode <= (k == 0);
      masterAbortDet <= (k == 0);
      masterArbLost <= (k == 1);
      slaveReadReq <= (k == 3);
      slaveTxActive <= (k == 2 || k == 5);
      sdaDrive <= 1'b1;
      bitLvl <= (k == 5);
      launch <= (k == 2 || k == 5);
      slaveReadServing <= (k == 4);
      @(posedge clk);
      {masterAbortDet, masterArbLost, slaveReadReq, launch} <= 4'h0;
      if (k == 4) axi_wr(`IATS_OFS_DATA_CMD, 32'h0000_0100, rs);
      repeat (24) @(posedge clk);
      {slaveTxActive, slaveReadServing} <= 2'h0;
   endtask : fire
   // Verdict and end of run
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd_chk(`IATS_OFS_CAUSE, 32'h0, `IATS_RESP_OKAY);
      foreach (rows[i]) begin
         axi_wr(`IATS_OFS_ENABLE, {30'h0, rows[i].kind == 0, 1'b1}, rs);
         repeat (rows[i].pushes) axi_wr(`IATS_OFS_DATA_CMD, 32'h0000_0055, rs);
         chk({27'h0, txLevel}, 32'(rows[i].pushes));
         fire(rows[i].kind);
         chk({27'h0, txLevel}, (rows[i].kind == 5) ? 32'(rows[i].pushes) : 32'h0);
         rd_chk(`IATS_OFS_CAUSE, rows[i].cause, `IATS_RESP_OKAY);
         axi_wr(`IATS_OFS_ENABLE, 32'h0, rs);
         rd_chk(`IATS_OFS_CAUSE, rows[i].cause & 32'h007F_FFFF, `IATS_RESP_OKAY);
         rd_chk((i % 2) ? `IATS_OFS_ALL_CLR : `IATS_OFS_ABRT_CLR, 32'h0, `IATS_RESP_OKAY);
         rd_chk(`IATS_OFS_CAUSE, 32'h0, `IATS_RESP_OKAY);
      end
      axi_wr(`IATS_OFS_CAUSE, 32'hFFFF_FFFF, rs);
      chk({30'h0, rs}, {30'h0, `IATS_RESP_OKAY});
      rd_chk(`IATS_OFS_CAUSE, 32'h0, `IATS_RESP_OKAY);
      axi_wr(8'hFC, 32'h0000_0001, rs);
      chk({30'h0, rs}, {30'h0, `IATS_RESP_SLVERR});
      rd_chk(8'hFC, 32'h0, `IATS_RESP_SLVERR);
      masterMode <= 1'b1;
      axi_wr(`IATS_OFS_CONTROL, 32'h0, rs);
      axi_wr(`IATS_OFS_TARGET, 32'h0000_0C00, rs);
      axi_wr(`IATS_OFS_DATA_CMD, 32'h0, rs);
      rd_chk(`IATS_OFS_CAUSE, 32'h0000_0200, `IATS_RESP_OKAY);
      rd_chk(`IATS_OFS_ABRT_CLR, 32'h0, `IATS_RESP_OKAY);
      rd_chk(`IATS_OFS_CAUSE, 32'h0000_0200, `IATS_RESP_OKAY);
      axi_wr(`IATS_OFS_CONTROL, 32'h0000_0020, rs);
      chk({31'h0, restartEn}, 32'h1);
      rd_chk(`IATS_OFS_ALL_CLR, 32'h0, `IATS_RESP_OKAY);
      rd_chk(`IATS_OFS_CAUSE, 32'h0, `IATS_RESP_OKAY);
      // Clear read wipes flush count
      axi_wr(`IATS_OFS_ENABLE, 32'h0000_0001, rs);
      repeat (2) axi_wr(`IATS_OFS_DATA_CMD, 32'h0000_0055, rs);
      fire(1);
      rd_chk(`IATS_OFS_CAUSE, 32'h0100_1000, `IATS_RESP_OKAY);
      rd_chk(`IATS_OFS_ABRT_CLR, 32'h0, `IATS_RESP_OKAY);
      rd_chk(`IATS_OFS_CAUSE, 32'h0, `IATS_RESP_OKAY);
      // Mid-run reset
      fire(1);
      rd_chk(`IATS_OFS_CAUSE, 32'h0000_1000, `IATS_RESP_OKAY);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd_chk(`IATS_OFS_CAUSE, 32'h0, `IATS_RESP_OKAY);
      clkEn <= 1'b0;
      repeat (2) @(posedge clk);
      chk({29'h0, awready, wready, arready}, 32'h0);
      complete_run();
   end
endmodule : iats_abort_status_tb
